// [verilog/jbs_data_path.sv]
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Bypass is one shift stage, loaded with zero in capture when selected.
// - Identification register is 32 bits: version, part, maker, fixed one.
// - Version field follows silicon revision, first revision zero.
// - Instruction register powers up holding identification opcode one.
// - Reset stage holding one keeps chip in reset immediately, unlatched.
// - After reset stage clears, chip stays in reset for fuse-selected time-out.
// - Instruction register is four bits wide.
// - All shift registers shift least significant bit first, in and out.
// - Opcode zero selects boundary chain; latched outputs drive pins at once.
// - Extest captures pins, shifts chain, update applies chain to pins.
// - Opcode two captures pins, update loads latches without driving pins.
// - Opcode twelve selects reset stage and never resets test port.
// - Opcode fifteen selects the bypass stage.
// - No high-impedance opcode; chip reset tri-states port pins instead, except under extest, where the update latches drive them.
// - Pull-ups disabled while extest or sample/preload is held.
// - Each port cell has an enable stage and a value stage.
// - Value from port register, enable from direction, pull-up from expression.
// - System clock not driven to pins, never sampled, during boundary scan.
// - Reset input, test enable, clock input have observe-only cells.
// - Reset output pin has an output cell without pull-up.
// - Analog control signals forced off during boundary scan.
// - Port works only with fuse programmed and disable bit clear.
// - Test reset sets a flag; power-on or software zero clears it.
module jbs_data_path #(
    parameter int NUM_PINS = 34,
    parameter int NUM_ANALOG = 4,
    parameter logic [3:0] ID_VERSION = jbs_pkg::ID_VERSION_DEFAULT,
    // Arbitrary identification values
    parameter logic [15:0] ID_PART = jbs_pkg::ID_PART_DEFAULT,
    parameter logic [10:0] ID_MAKER = jbs_pkg::ID_MAKER_DEFAULT,
    parameter int TIMEOUT_SHORT = jbs_pkg::TIMEOUT_SHORT_CYCLES,
    parameter int TIMEOUT_LONG = jbs_pkg::TIMEOUT_LONG_CYCLES
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic reset,
    // Test link pins and controller state, all asynchronous
    input wire logic tck,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic capture_dr,
    input wire logic shift_dr,
    input wire logic update_dr,
    input wire logic update_ir,
    input wire logic test_logic_reset,
    input wire logic [jbs_pkg::IR_WIDTH-1:0] ir_new,
    // Fuses
    input wire logic test_port_enable_fuse,
    input wire logic clock_output_fuse,
    input wire logic timeout_long_fuse,
    // Register port
    input wire logic [jbs_pkg::ADDR_WIDTH-1:0] reg_addr,
    input wire logic [jbs_pkg::DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [jbs_pkg::DATA_WIDTH-1:0] reg_rdata,
    // Core side of the port pins
    input wire logic [NUM_PINS-1:0] pin_direction_bit,
    input wire logic [NUM_PINS-1:0] pin_output_register_bit,
    input wire logic global_pullup_disable,
    output logic [NUM_PINS-1:0] pin_input_register_bit,
    // Port pads
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out_value,
    output logic [NUM_PINS-1:0] pin_out_enable,
    output logic [NUM_PINS-1:0] pin_pullup_enable,
    // Observed input pins
    input wire logic reset_input_n,
    input wire logic test_program_enable,
    input wire logic clock_input_pin,
    // Reset output pin and its core source
    input wire logic core_reset_out_n,
    output logic reset_output_n,
    // Clock output gate and analog controls
    output logic clock_output_enable,
    input wire logic [NUM_ANALOG-1:0] analog_ctrl_in,
    output logic [NUM_ANALOG-1:0] analog_ctrl_out,
    // Chip reset and its source flag
    output logic chip_reset,
    output logic test_reset_flag
);
    import jbs_pkg::*;

    localparam int CHAIN_LEN = 2 * NUM_PINS + TAIL_CELLS;
    localparam int TAIL = 2 * NUM_PINS;
    localparam int SYNC_W = 11 + NUM_PINS;

    function automatic logic is_scan(input logic [IR_WIDTH-1:0] op);
        is_scan = (op == OP_EXTEST) || (op == OP_SAMPLE_PRELOAD);
    endfunction : is_scan

    // Two-stage synchronisers for every pin-side input
    logic [SYNC_W-1:0] sync1_q, sync2_q;
    always_ff @(posedge clk) begin
        sync1_q <= {pin_in, tck, tdi, capture_dr, shift_dr, update_dr, update_ir,
                    test_logic_reset, ir_new};
        sync2_q <= sync1_q;
    end
    logic [NUM_PINS-1:0] pin_s;
    logic tck_s, tdi_s, cap_s, shf_s, upd_s, updir_s, tlr_s, tck_prev_q;
    logic [IR_WIDTH-1:0] irnew_s;
    assign {pin_s, tck_s, tdi_s, cap_s, shf_s, upd_s, updir_s, tlr_s, irnew_s} = sync2_q;

    logic [2:0] obs1_q, obs_q;
    always_ff @(posedge clk) begin
        obs1_q <= {reset_input_n, test_program_enable, clock_input_pin};
        obs_q <= obs1_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= tck_s;
        end
    end
    logic tck_rise, tck_fall;
    assign tck_rise = tck_s & ~tck_prev_q;
    assign tck_fall = ~tck_s & tck_prev_q;

    // Control register and port enable
    logic disable_q, port_en;
    assign port_en = test_port_enable_fuse & ~disable_q;

    // Instruction register
    logic [IR_WIDTH-1:0] ir_q;
    always_ff @(posedge clk) begin
        if (reset || !port_en || tlr_s) begin
            ir_q <= IR_RESET_VALUE;
        end else if (tck_rise && updir_s) begin
            ir_q <= irnew_s;
        end
    end

    logic scan_mode, extest;
    assign scan_mode = port_en & is_scan(ir_q);
    assign extest = port_en & (ir_q == OP_EXTEST);
    logic sel_chain, sel_id, sel_rst, sel_bypass;
    assign sel_chain = is_scan(ir_q);
    assign sel_id = (ir_q == OP_IDCODE);
    assign sel_rst = (ir_q == OP_CHIP_RESET);
    assign sel_bypass = !(sel_chain || sel_id || sel_rst);
    logic dr_cap, dr_shift;
    assign dr_cap = port_en & tck_rise & cap_s;
    assign dr_shift = port_en & tck_rise & shf_s;

    // Bypass stage
    logic bypass_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            bypass_q <= BYPASS_CAPTURE_VALUE;
        end else if (sel_bypass && dr_cap) begin
            bypass_q <= BYPASS_CAPTURE_VALUE;
        end else if (sel_bypass && dr_shift) begin
            bypass_q <= tdi_s;
        end
    end

    // Identification register
    logic [ID_WIDTH-1:0] id_value;
    assign id_value = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_BIT};
    logic [ID_WIDTH-1:0] id_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            id_q <= '0;
        end else if (sel_id && dr_cap) begin
            id_q <= id_value;
        end else if (sel_id && dr_shift) begin
            id_q <= {tdi_s, id_q[ID_WIDTH-1:1]};
        end
    end

    // Reset stage; its output feeds chip reset directly, no update latch
    logic rst_reg_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            rst_reg_q <= 1'b0;
        end else if (!port_en) begin
            rst_reg_q <= 1'b0;
        end else if (sel_rst && dr_shift) begin
            rst_reg_q <= tdi_s;
        end
    end

    // Boundary chain capture values
    logic [CHAIN_LEN-1:0] cap_val, chain_q, latch_q;
    logic [NUM_PINS-1:0] upd_en, upd_val;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_cell
            assign cap_val[2*gi] = pin_direction_bit[gi];
            assign cap_val[2*gi+1] = pin_s[gi];
            assign upd_en[gi] = latch_q[2*gi];
            assign upd_val[gi] = latch_q[2*gi+1];
        end
    endgenerate
    // Three observe-only cells and the reset output cell; the output clock has no cell, so it is never sampled
    assign cap_val[TAIL+CELL_CLOCK_INPUT] = obs_q[0];
    assign cap_val[TAIL+CELL_TEST_ENABLE] = obs_q[1];
    assign cap_val[TAIL+CELL_RESET_INPUT] = obs_q[2];
    assign cap_val[TAIL+CELL_RESET_OUTPUT] = core_reset_out_n;

    always_ff @(posedge clk) begin
        if (reset) begin
            chain_q <= '0;
        end else if (sel_chain && dr_cap) begin
            chain_q <= cap_val;
        end else if (sel_chain && dr_shift) begin
            chain_q <= {tdi_s, chain_q[CHAIN_LEN-1:1]};
        end
    end

    // Update latches; loaded under both scan opcodes, used at pins only in extest
    always_ff @(posedge clk) begin
        if (reset) begin
            latch_q <= '0;
        end else if (scan_mode && tck_rise && upd_s) begin
            latch_q <= chain_q;
        end
    end

    // Serial output changes on the falling edge, as the link expects
    logic tdo_d;
    always_comb begin
        tdo_d = bypass_q;
        if (sel_chain) begin
            tdo_d = chain_q[0];
        end else if (sel_id) begin
            tdo_d = id_q[0];
        end else if (sel_rst) begin
            tdo_d = rst_reg_q;
        end
    end
    logic tdo_q, tdo_oe_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (!port_en) begin
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q <= tdo_d;
            tdo_oe_q <= shf_s;
        end
    end
    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // Reset time-out sequencer
    jbs_reset_state_t state_q;
    logic [TIMEOUT_COUNT_WIDTH-1:0] tmo_q;
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= JBS_RUN;
            tmo_q <= '0;
        end else begin
            case (state_q)
                JBS_RUN: begin
                    if (rst_reg_q) begin
                        state_q <= JBS_HOLD;
                    end
                end
                JBS_HOLD: begin
                    if (!rst_reg_q) begin
                        state_q <= JBS_TIMEOUT;
                        tmo_q <= timeout_long_fuse ?
                            TIMEOUT_COUNT_WIDTH'(TIMEOUT_LONG) :
                            TIMEOUT_COUNT_WIDTH'(TIMEOUT_SHORT);
                    end
                end
                JBS_TIMEOUT: begin
                    if (rst_reg_q) begin
                        state_q <= JBS_HOLD;
                    end else if (tmo_q <= TIMEOUT_COUNT_WIDTH'(1)) begin
                        state_q <= JBS_RUN;
                    end else begin
                        tmo_q <= tmo_q - TIMEOUT_COUNT_WIDTH'(1);
                    end
                end
                default: begin
                    state_q <= JBS_RUN;
                end
            endcase
        end
    end

    // Reset stage acts in the same cycle; it is not waited for by the sequencer
    assign chip_reset = rst_reg_q | ~obs_q[2] | (state_q != JBS_RUN);

    // Pin drivers
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_out_value <= '0;
            pin_out_enable <= '0;
            pin_pullup_enable <= '0;
            pin_input_register_bit <= '0;
            reset_output_n <= 1'b0;
            clock_output_enable <= 1'b0;
            analog_ctrl_out <= '0;
        end else begin
            pin_input_register_bit <= pin_s;
            if (extest) begin
                pin_out_value <= upd_val;
                pin_out_enable <= upd_en;
                reset_output_n <= latch_q[TAIL+CELL_RESET_OUTPUT];
            end else begin
                pin_out_value <= pin_output_register_bit;
                // Pins tri-state in chip reset, which stands in for high-impedance
                pin_out_enable <= chip_reset ? '0 : pin_direction_bit;
                reset_output_n <= core_reset_out_n;
            end
            if (scan_mode) begin
                pin_pullup_enable <= '0;
            end else begin
                pin_pullup_enable <= ~pin_direction_bit & pin_output_register_bit
                    & {NUM_PINS{~global_pullup_disable}};
            end
            clock_output_enable <= clock_output_fuse & ~scan_mode;
            analog_ctrl_out <= scan_mode ? '0 : analog_ctrl_in;
        end
    end

    // Register port
    logic flag_q, flag_clear;
    assign flag_clear = reg_write && (reg_addr == REG_STATUS)
        && !reg_wdata[STAT_TEST_RESET_FLAG_BIT];
    always_ff @(posedge clk) begin
        if (reset) begin
            disable_q <= CTRL_DISABLE_RESET;
        end else if (reg_write && reg_addr == REG_CONTROL) begin
            disable_q <= reg_wdata[CTRL_DISABLE_BIT];
        end
    end
    // A new test reset in the clearing cycle keeps the flag set
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (rst_reg_q) begin
            flag_q <= 1'b1;
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end
    assign test_reset_flag = flag_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                REG_CONTROL: reg_rdata <= DATA_WIDTH'({disable_q, 7'h00});
                REG_STATUS: reg_rdata <= DATA_WIDTH'({flag_q, 4'h0});
                REG_INSTRUCTION: reg_rdata <= DATA_WIDTH'(ir_q);
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_BYPASS_CAPTURE: assert property (sel_bypass && dr_cap |=> !bypass_q)
        else $error("bypass not zero after capture");
    AST_ID_FIXED_ONE: assert property (sel_id && dr_cap |=> id_q[0]
        && id_q[31:28] == ID_VERSION) else $error("id capture wrong");
    AST_IR_DEFAULT: assert property ($past(reset) |-> ir_q == OP_IDCODE)
        else $error("ir not idcode after reset");
    AST_RESET_NOW: assert property (sel_rst && dr_shift && tdi_s |=> chip_reset)
        else $error("chip reset not immediate");
    AST_TIMEOUT_HOLD: assert property ($fell(rst_reg_q) |-> chip_reset [*8])
        else $error("reset released without time-out");
    AST_SHIFT_LSB: assert property (sel_id && dr_shift |=> id_q[31] == $past(tdi_s)
        && id_q[30:0] == $past(id_q[31:1])) else $error("id shift wrong");
    AST_EXTEST_DRIVE: assert property (extest |=> pin_out_value == $past(upd_val)
        && pin_out_enable == $past(upd_en)) else $error("extest pins wrong");
    AST_SAMPLE_NO_DRIVE: assert property (port_en && ir_q == OP_SAMPLE_PRELOAD
        |=> pin_out_value == $past(pin_output_register_bit)) else $error("preload drove");
    AST_PULLUP_OFF: assert property (scan_mode |=> pin_pullup_enable == '0)
        else $error("pull-up on in scan");
    AST_CLOCK_GATED: assert property (scan_mode |=> !clock_output_enable)
        else $error("clock out in scan");
    AST_ANALOG_OFF: assert property (scan_mode |=> analog_ctrl_out == '0)
        else $error("analog control on in scan");
    AST_PORT_DISABLED: assert property (!port_en |=> !tdo_oe && ir_q == OP_IDCODE)
        else $error("port active while disabled");
    AST_FLAG_SET: assert property (rst_reg_q |=> test_reset_flag)
        else $error("test reset flag not set");

    COV_EXTEST: cover property (extest ##1 tck_rise && upd_s);
    COV_TIMEOUT_END: cover property (state_q == JBS_TIMEOUT ##1 state_q == JBS_RUN);
    COV_ID_SHIFT: cover property (sel_id && dr_cap ##[1:600] sel_id && dr_shift);
endmodule : jbs_data_path

// [verilog/jbs_pkg.sv]
package jbs_pkg;
    // Instruction register and opcodes
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] OP_EXTEST = 4'h0;
    localparam logic [3:0] OP_IDCODE = 4'h1;
    localparam logic [3:0] OP_SAMPLE_PRELOAD = 4'h2;
    localparam logic [3:0] OP_CHIP_RESET = 4'hC;
    localparam logic [3:0] OP_BYPASS = 4'hF;
    localparam logic [3:0] IR_RESET_VALUE = OP_IDCODE;

    // Identification register layout
    localparam int ID_WIDTH = 32;
    localparam int ID_VERSION_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MAKER_LSB = 1;
    localparam logic ID_FIXED_BIT = 1'b1;

    // Bypass stage value loaded in capture
    localparam logic BYPASS_CAPTURE_VALUE = 1'b0;

    // Register port
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 8;
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_INSTRUCTION = 4'h2;
    localparam int CTRL_DISABLE_BIT = 7;
    localparam int STAT_TEST_RESET_FLAG_BIT = 4;
    localparam logic CTRL_DISABLE_RESET = 1'b0;

    // Chain tail cells after the port pin cells
    localparam int CELL_CLOCK_INPUT = 0;
    localparam int CELL_RESET_INPUT = 1;
    localparam int CELL_TEST_ENABLE = 2;
    localparam int CELL_RESET_OUTPUT = 3;
    localparam int TAIL_CELLS = 4;

    // Reset time-out after release of the reset stage, in clk cycles
    localparam int TIMEOUT_SHORT_CYCLES = 16;
    localparam int TIMEOUT_LONG_CYCLES = 4096;
    localparam int TIMEOUT_COUNT_WIDTH = 13;

    // Defaults for the identification fields
    localparam logic [3:0] ID_VERSION_DEFAULT = 4'h0;
    localparam logic [15:0] ID_PART_DEFAULT = 16'h5A5A;
    localparam logic [10:0] ID_MAKER_DEFAULT = 11'h2A5;

    typedef enum logic [2:0] {
        JBS_RUN = 3'b001,
        JBS_HOLD = 3'b010,
        JBS_TIMEOUT = 3'b100
    } jbs_reset_state_t;
endpackage : jbs_pkg

// [bench/jbs_jtag_ctrl.sv]
`timescale 1ns/1ps
module jbs_jtag_ctrl (
    // Pacing clock and serial return
    input wire logic clk,
    input wire logic tdo,
    // Link pins and controller state levels
    output logic tck,
    output logic tdi,
    output logic capture_dr,
    output logic shift_dr,
    output logic update_dr,
    output logic update_ir,
    output logic test_logic_reset,
    output logic [jbs_pkg::IR_WIDTH-1:0] ir_new
);
    import jbs_pkg::*;

    // Link clock stands low between frames
    initial begin
        tck = 1'b0;
        tdi = 1'b0;
        capture_dr = 1'b0;
        shift_dr = 1'b0;
        update_dr = 1'b0;
        update_ir = 1'b0;
        test_logic_reset = 1'b0;
        ir_new = OP_IDCODE;
    end

    // One 1000 ns link period; tdo is read late in the high phase, well after its last change
    task automatic pulse(output logic seen);
        repeat (2) @(posedge clk);
        tck <= 1'b1;
        repeat (4) @(posedge clk);
        seen = tdo;
        tck <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic load_ir(input logic [IR_WIDTH-1:0] op);
        logic seen;
        @(posedge clk);
        ir_new <= op;
        update_ir <= 1'b1;
        pulse(seen);
        update_ir <= 1'b0;
        ir_new <= ~op;
    endtask : load_ir

    task automatic scan_dr(input int n, input logic [63:0] din, output logic [63:0] dout);
        logic seen;
        dout = '0;
        @(posedge clk);
        capture_dr <= 1'b1;
        pulse(seen);
        capture_dr <= 1'b0;
        shift_dr <= 1'b1;
        for (int i = 0; i < n; i++) begin
            tdi <= din[i];
            pulse(seen);
            dout[i] = seen;
        end
        shift_dr <= 1'b0;
        update_dr <= 1'b1;
        // Released data line shows the inverse of the last bit
        tdi <= ~din[n-1];
        pulse(seen);
        update_dr <= 1'b0;
    endtask : scan_dr
endmodule : jbs_jtag_ctrl

// [bench/jtag_boundary_scan_data_path_tb.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module jtag_boundary_scan_data_path_tb;
    import jbs_pkg::*;
    localparam int NP = 4;
    localparam int CH = 2 * NP + 4;
    localparam logic [CH-1:0] PRE = 12'hB4D;
    logic clk, reset, tck, tdi, tdo, tdo_oe, capture_dr, shift_dr, update_dr, update_ir;
    logic test_logic_reset, test_port_enable_fuse, clock_output_fuse, timeout_long_fuse;
    logic [3:0] ir_new, reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic reg_write, reg_read, global_pullup_disable, reset_input_n, test_program_enable;
    logic clock_input_pin, core_reset_out_n, reset_output_n, clock_output_enable;
    logic chip_reset, test_reset_flag;
    logic [NP-1:0] pin_direction_bit, pin_output_register_bit, pin_input_register_bit, pin_in;
    logic [NP-1:0] pin_out_value, pin_out_enable, pin_pullup_enable;
    logic [3:0] analog_ctrl_in, analog_ctrl_out;
    logic [CH-1:0] cap_exp;
    int n_errors = 0;
    int check_count = 0;

    jbs_data_path #(.NUM_PINS(NP), .TIMEOUT_SHORT(8), .TIMEOUT_LONG(40)) uut (
        .clk, .reset, .tck, .tdi, .tdo, .tdo_oe, .capture_dr, .shift_dr, .update_dr,
        .update_ir, .test_logic_reset, .ir_new, .test_port_enable_fuse, .clock_output_fuse,
        .timeout_long_fuse, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .pin_direction_bit, .pin_output_register_bit, .global_pullup_disable,
        .pin_input_register_bit, .pin_in, .pin_out_value, .pin_out_enable, .pin_pullup_enable,
        .reset_input_n, .test_program_enable, .clock_input_pin, .core_reset_out_n,
        .reset_output_n, .clock_output_enable, .analog_ctrl_in, .analog_ctrl_out,
        .chip_reset, .test_reset_flag);

    jbs_jtag_ctrl ctl (.clk, .tdo, .tck, .tdi, .capture_dr, .shift_dr, .update_dr,
        .update_ir, .test_logic_reset, .ir_new);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic close_out();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : reg_rd

    task automatic chk_pins(input logic [CH-1:0] v);
        for (int i = 0; i < NP; i++) begin
            `CHK(pin_out_enable[i], v[2*i])
            `CHK(pin_out_value[i], v[2*i+1])
        end
        `CHK(reset_output_n, v[CH-1])
        `CHK(pin_pullup_enable, 4'h0)
        `CHK(clock_output_enable, 1'b0)
    endtask : chk_pins

    task automatic t_idcode();
        logic [63:0] d;
        logic [7:0] r;
        reg_rd(REG_INSTRUCTION, r);
        `CHK(r, {4'h0, OP_IDCODE})
        ctl.scan_dr(ID_WIDTH, 64'h0, d);
        `CHK(d[31:0], {ID_VERSION_DEFAULT, ID_PART_DEFAULT, ID_MAKER_DEFAULT, 1'b1})
        `CHK(d[31:28], 4'h0)
    endtask : t_idcode

    task automatic t_disable();
        logic [7:0] r;
        reg_wr(REG_CONTROL, 8'h80);
        ctl.load_ir(OP_BYPASS);
        reg_rd(REG_INSTRUCTION, r);
        `CHK(r, 8'h01)
        `CHK(tdo_oe, 1'b0)
        reg_rd(REG_CONTROL, r);
        `CHK(r, 8'h80)
        reg_wr(REG_CONTROL, 8'h00);
        reg_rd(4'hF, r);
        `CHK(r, 8'h00)
    endtask : t_disable

    // Unassigned and private codes must behave like the bypass code
    task automatic t_bypass();
        logic [3:0] ops [7] = '{4'h3, 4'h5, 4'h8, 4'hB, 4'hD, 4'hE, OP_BYPASS};
        logic [63:0] d;
        logic [7:0] r;
        foreach (ops[k]) begin
            ctl.load_ir(ops[k]);
            reg_rd(REG_INSTRUCTION, r);
            `CHK(r, {4'h0, ops[k]})
            ctl.scan_dr(3, 64'h5, d);
            `CHK(d[2:0], 3'b010)
        end
    endtask : t_bypass

    task automatic t_sample();
        logic [63:0] d;
        for (int i = 0; i < NP; i++) begin
            cap_exp[2*i] = pin_direction_bit[i];
            cap_exp[2*i+1] = pin_in[i];
        end
        cap_exp[CH-1:CH-4] = {core_reset_out_n, test_program_enable, reset_input_n,
            clock_input_pin};
        `CHK(pin_pullup_enable, ~pin_direction_bit & pin_output_register_bit)
        `CHK(pin_input_register_bit, pin_in)
        `CHK(clock_output_enable, 1'b1)
        `CHK(analog_ctrl_out, analog_ctrl_in)
        global_pullup_disable <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(pin_pullup_enable, 4'h0)
        global_pullup_disable <= 1'b0;
        repeat (2) @(posedge clk);
        ctl.load_ir(OP_SAMPLE_PRELOAD);
        `CHK(pin_pullup_enable, 4'h0)
        `CHK(clock_output_enable, 1'b0)
        `CHK(analog_ctrl_out, 4'h0)
        ctl.scan_dr(CH, {52'h0, PRE}, d);
        `CHK(d[CH-1:0], cap_exp)
        `CHK(pin_out_value, pin_output_register_bit)
        `CHK(pin_out_enable, pin_direction_bit)
        `CHK(reset_output_n, core_reset_out_n)
    endtask : t_sample

    task automatic t_extest();
        logic [63:0] d;
        ctl.load_ir(OP_EXTEST);
        chk_pins(PRE);
        ctl.scan_dr(CH, {52'h0, ~PRE}, d);
        `CHK(d[CH-1:0], cap_exp)
        chk_pins(~PRE);
    endtask : t_extest

    task automatic t_reset();
        logic [63:0] d;
        logic [7:0] r;
        int n;
        ctl.load_ir(OP_CHIP_RESET);
        ctl.scan_dr(1, 64'h1, d);
        `CHK(chip_reset, 1'b1)
        `CHK(pin_out_enable, 4'h0)
        `CHK(test_reset_flag, 1'b1)
        reg_rd(REG_INSTRUCTION, r);
        `CHK(r, 8'h0C)
        reg_rd(REG_STATUS, r);
        `CHK(r[STAT_TEST_RESET_FLAG_BIT], 1'b1)
        ctl.scan_dr(1, 64'h0, d);
        `CHK(chip_reset, 1'b1)
        n = 0;
        while (chip_reset === 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        `CHK(chip_reset, 1'b0)
        `CHK(n > 10, 1'b1)
        reg_wr(REG_STATUS, 8'h00);
        reg_rd(REG_STATUS, r);
        `CHK(r, 8'h00)
        ctl.scan_dr(1, 64'h1, d);
        timeout_long_fuse <= 1'b0;
        ctl.scan_dr(1, 64'h0, d);
        `CHK(chip_reset, 1'b0)
        `CHK(test_reset_flag, 1'b1)
    endtask : t_reset

    initial begin
        #2000000;
        n_errors++;
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 0, 1);
        close_out();
    end

    initial begin
        reset = 1'b1;
        test_port_enable_fuse = 1'b1;
        clock_output_fuse = 1'b1;
        timeout_long_fuse = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        pin_direction_bit = 4'h6;
        pin_output_register_bit = 4'hC;
        global_pullup_disable = 1'b0;
        pin_in = 4'hA;
        reset_input_n = 1'b1;
        test_program_enable = 1'b0;
        clock_input_pin = 1'b1;
        core_reset_out_n = 1'b1;
        analog_ctrl_in = 4'hF;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        t_idcode();
        t_disable();
        t_bypass();
        t_sample();
        t_extest();
        t_reset();
        close_out();
    end
endmodule : jtag_boundary_scan_data_path_tb
